// *** rtl/csp_baud.v ***
// Oversampling tick divider for one serial port
`timescale 1ns/10ps
`default_nettype none
`include "csp_regs.vh"
module csp_baud #(
  parameter CLK_HZ = `CSP_CLK_HZ
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Control
  input wire [3:0] rate_i,
  input wire restart_i,
  // Tick at sixteen times the bit rate
  output reg tick_o
);
  reg [15:0] cnt_q;
  wire [15:0] div_w;

  function [15:0] csp_div;
    input [3:0] sel;
    integer r;
    integer d;
    begin
      case (sel)
        4'h0: r = `CSP_BAUD_0;
        4'h1: r = `CSP_BAUD_1;
        4'h2: r = `CSP_BAUD_2;
        4'h3: r = `CSP_BAUD_3;
        4'h4: r = `CSP_BAUD_4;
        4'h5: r = `CSP_BAUD_5;
        4'h6: r = `CSP_BAUD_6;
        4'h7: r = `CSP_BAUD_7;
        4'h8: r = `CSP_BAUD_8;
        4'h9: r = `CSP_BAUD_9;
        4'ha: r = `CSP_BAUD_10;
        4'hb: r = `CSP_BAUD_11;
        default: r = `CSP_BAUD_3;
      endcase
      // Rounded to nearest, error stays below 2 % at the fastest rate
      d = (CLK_HZ + (`CSP_OVS / 2) * r) / (`CSP_OVS * r);
      if (d < 1) d = 1;
      csp_div = d[15:0];
    end
  endfunction

  assign div_w = csp_div(rate_i);

  always @(posedge clock_i) begin
    if (reset_i || restart_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q >= div_w - 16'h0001) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/csp_regs.vh ***
// Register offsets, field positions, reset values and timing counts of the serial port
`ifndef CSP_REGS_VH
`define CSP_REGS_VH

// Byte offsets inside one port window
`define CSP_OFF_CTRL 5'h00
`define CSP_OFF_STAT 5'h04
`define CSP_OFF_MASK 5'h08
`define CSP_OFF_TXD 5'h0c
`define CSP_OFF_RXD 5'h10
// Address bit that selects the port, bits above it must be zero
`define CSP_PORT_BIT 5

// Control fields
`define CSP_C_NINE 0
`define CSP_C_ODD 1
`define CSP_C_STLVL 2
`define CSP_C_SPLVL 3
`define CSP_C_MSB 4
`define CSP_C_FLOW 5
`define CSP_C_RATE 8
`define CSP_CTRL_W 12
`define CSP_CTRL_RST 12'h308

// Status fields, events are sticky and cleared by writing one
`define CSP_S_RXDONE 0
`define CSP_S_TXDONE 1
`define CSP_S_PERR 2
`define CSP_S_FERR 3
`define CSP_S_OVR 4
`define CSP_EVT_W 5
`define CSP_S_TXBUSY 8
`define CSP_S_RXFULL 9
`define CSP_MASK_RST 5'h00

// Timing
`define CSP_CLK_HZ 100000000
`define CSP_OVS 16
`define CSP_OVS_MID 4'h7
`define CSP_OVS_LAST 4'hf
`define CSP_RATE_DEF 4'h3
`define CSP_BAUD_0 1200
`define CSP_BAUD_1 2400
`define CSP_BAUD_2 4800
`define CSP_BAUD_3 9600
`define CSP_BAUD_4 14400
`define CSP_BAUD_5 19200
`define CSP_BAUD_6 28800
`define CSP_BAUD_7 38400
`define CSP_BAUD_8 57600
`define CSP_BAUD_9 76800
`define CSP_BAUD_10 115200
`define CSP_BAUD_11 230400

// Frame bit index of the stop bit, counted from the start bit
`define CSP_LAST_SHORT 4'h9
`define CSP_LAST_LONG 4'ha

`endif

// *** rtl/csp_rx.v ***
// Frame receiver of one serial port
`timescale 1ns/10ps
`default_nettype none
`include "csp_regs.vh"
module csp_rx (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Timing and line
  input wire tick_i,
  input wire rxd_i,
  // Frame format
  input wire nine_i,
  input wire odd_i,
  input wire start_lvl_i,
  input wire stop_lvl_i,
  input wire msb_i,
  // Received frame, flags are one-cycle pulses with done
  output reg [7:0] data_o,
  output reg done_o,
  output reg perr_o,
  output reg ferr_o
);
  localparam S_IDLE = 2'b01;
  localparam S_RUN = 2'b10;
  reg [1:0] st_q;
  reg [3:0] sub_q;
  reg [3:0] idx_q;
  reg [7:0] sh_q;
  reg par_q;
  wire [3:0] last_w;

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) rev8[i] = v[7 - i];
    end
  endfunction

  assign last_w = nine_i ? `CSP_LAST_LONG : `CSP_LAST_SHORT;

  always @(posedge clock_i) begin
    done_o <= 1'b0;
    perr_o <= 1'b0;
    ferr_o <= 1'b0;
    if (reset_i) begin
      st_q <= S_IDLE;
      sub_q <= 4'h0;
      idx_q <= 4'h0;
      sh_q <= 8'h00;
      par_q <= 1'b0;
      data_o <= 8'h00;
    end else if (tick_i) begin
      case (st_q)
        S_IDLE: begin
          // Idle line rests at the stop level
          if (rxd_i == start_lvl_i && rxd_i != stop_lvl_i) begin
            st_q <= S_RUN;
            sub_q <= 4'h0;
            idx_q <= 4'h0;
          end
        end
        S_RUN: begin
          sub_q <= sub_q + 4'h1;
          if (sub_q == `CSP_OVS_MID) begin
            idx_q <= idx_q + 4'h1;
            if (idx_q == 4'h0) begin
              // Glitch shorter than half a bit is dropped
              if (rxd_i != start_lvl_i) st_q <= S_IDLE;
            end else if (idx_q < 4'h9) begin
              sh_q <= {rxd_i, sh_q[7:1]};
            end else if (idx_q != last_w) begin
              par_q <= rxd_i;
            end else begin
              st_q <= S_IDLE;
              done_o <= 1'b1;
              data_o <= msb_i ? rev8(sh_q) : sh_q;
              perr_o <= nine_i && (par_q != (odd_i ? ~^sh_q : ^sh_q));
              ferr_o <= rxd_i != stop_lvl_i;
            end
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** rtl/csp_top.v ***
// Dual asynchronous serial port with register port and interrupt
// What this block does
// - Two identical ports, each with own configuration and status.
// - Short payload: eight data bits, no parity bit.
// - Long payload: eight data bits then one parity bit.
// - Parity odd or even by software; generated on send, checked on receive.
// - Start and stop bit levels are each selectable; both ends agree.
// - Data bit order LSB first or MSB first, both directions.
// - Receiver flags parity mismatch and wrong stop level.
// - Switchable flow control: hold frames when partner not ready; signal own readiness.
// - Bit rate from twelve rates, 1.2 to 230.4 kilobaud.
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "csp_regs.vh"
module csp_top #(
  parameter CLK_HZ = `CSP_CLK_HZ,
  parameter PORTS = 2
) (
  // Clock and reset
  input wire clock_i,
  input wire reset_i,
  // Register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // Interrupt
  output reg irq_o,
  // Serial lines
  input wire [PORTS-1:0] rxd_i,
  output wire [PORTS-1:0] txd_o,
  input wire [PORTS-1:0] peer_ready_i,
  output wire [PORTS-1:0] own_ready_o
);
  localparam T_IDLE = 3'b001;
  localparam T_HOLD = 3'b010;
  localparam T_SEND = 3'b100;

  wire [32*PORTS-1:0] rd_f;
  wire [PORTS-1:0] irq_f;
  wire win_w;

  function [7:0] rev8;
    input [7:0] v;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1) rev8[i] = v[7 - i];
    end
  endfunction

  // Strobe and offset decode, shared by every register of a port
  function reg_hit;
    input strobe;
    input [4:0] a;
    input [4:0] off;
    begin
      reg_hit = strobe && (a == off);
    end
  endfunction

  // Upper address bits must be zero so the window does not alias
  assign win_w = addr_i[7:`CSP_PORT_BIT+1] == 2'b00;

  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      reg [`CSP_CTRL_W-1:0] ctrl_q;
      reg [`CSP_EVT_W-1:0] stat_q;
      reg [`CSP_EVT_W-1:0] mask_q;
      reg [`CSP_EVT_W-1:0] set_d;
      reg [7:0] rxbuf_q;
      reg rxfull_q;
      reg ready_q;
      reg [2:0] tst_q;
      reg [10:0] tsh_q;
      reg [3:0] tsub_q;
      reg [3:0] tidx_q;
      reg txd_q;
      reg tdone_q;
      reg [31:0] prd_d;
      wire sel_w;
      wire wr_w;
      wire rd_w;
      wire tick_w;
      wire [7:0] rdat_w;
      wire rdone_w;
      wire perr_w;
      wire ferr_w;
      wire nine_w;
      wire odd_w;
      wire stl_w;
      wire spl_w;
      wire msb_w;
      wire flow_w;
      wire [7:0] tord_w;
      wire tpar_w;
      wire [3:0] tlast_w;
      wire txbusy_w;
      // Register strobes of this port
      wire ctrl_we_w;
      wire stat_we_w;
      wire mask_we_w;
      wire txd_we_w;
      wire rxd_re_w;
      // Payload width of the frame in flight
      reg tnine_q;

      assign sel_w = win_w && (addr_i[`CSP_PORT_BIT] == p);
      assign wr_w = wr_i && sel_w;
      assign rd_w = rd_i && sel_w;
      assign nine_w = ctrl_q[`CSP_C_NINE];
      assign odd_w = ctrl_q[`CSP_C_ODD];
      assign stl_w = ctrl_q[`CSP_C_STLVL];
      assign spl_w = ctrl_q[`CSP_C_SPLVL];
      assign msb_w = ctrl_q[`CSP_C_MSB];
      assign flow_w = ctrl_q[`CSP_C_FLOW];

      assign ctrl_we_w = reg_hit(wr_w, addr_i[4:0], `CSP_OFF_CTRL);
      assign stat_we_w = reg_hit(wr_w, addr_i[4:0], `CSP_OFF_STAT);
      assign mask_we_w = reg_hit(wr_w, addr_i[4:0], `CSP_OFF_MASK);
      assign txd_we_w = reg_hit(wr_w, addr_i[4:0], `CSP_OFF_TXD);
      assign rxd_re_w = reg_hit(rd_w, addr_i[4:0], `CSP_OFF_RXD);
      // A queued frame waiting on flow control counts as busy
      assign txbusy_w = ~tst_q[0];

      // Rate change restarts the divider so no short tick leaks out
      csp_baud #(
        .CLK_HZ(CLK_HZ)
      ) u_baud (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .rate_i(ctrl_q[`CSP_C_RATE+3:`CSP_C_RATE]),
        .restart_i(ctrl_we_w),
        .tick_o(tick_w)
      );

      csp_rx u_rx (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .tick_i(tick_w),
        .rxd_i(rxd_i[p]),
        .nine_i(nine_w),
        .odd_i(odd_w),
        .start_lvl_i(stl_w),
        .stop_lvl_i(spl_w),
        .msb_i(msb_w),
        .data_o(rdat_w),
        .done_o(rdone_w),
        .perr_o(perr_w),
        .ferr_o(ferr_w)
      );

      // Configuration registers
      always @(posedge clock_i) begin
        if (reset_i) begin
          ctrl_q <= `CSP_CTRL_RST;
          mask_q <= `CSP_MASK_RST;
        end else if (ctrl_we_w) begin
          ctrl_q <= wdata_i[`CSP_CTRL_W-1:0];
        end else if (mask_we_w) begin
          mask_q <= wdata_i[`CSP_EVT_W-1:0];
        end
      end

      // Events of this cycle
      always @* begin
        set_d = {`CSP_EVT_W{1'b0}};
        set_d[`CSP_S_RXDONE] = rdone_w;
        set_d[`CSP_S_TXDONE] = tdone_q;
        set_d[`CSP_S_PERR] = perr_w;
        set_d[`CSP_S_FERR] = ferr_w;
        // A read in the same cycle does not save the old byte
        set_d[`CSP_S_OVR] = rdone_w && rxfull_q;
      end

      // Sticky status, a new event wins over the write-one clear
      always @(posedge clock_i) begin
        if (reset_i) begin
          stat_q <= {`CSP_EVT_W{1'b0}};
        end else if (stat_we_w) begin
          stat_q <= (stat_q & ~wdata_i[`CSP_EVT_W-1:0]) | set_d;
        end else begin
          stat_q <= stat_q | set_d;
        end
      end

      // Receive holding register, a landing frame wins over the read that empties it
      always @(posedge clock_i) begin
        if (reset_i) begin
          rxbuf_q <= 8'h00;
          rxfull_q <= 1'b0;
          ready_q <= 1'b1;
        end else begin
          if (rdone_w) begin
            rxbuf_q <= rdat_w;
            rxfull_q <= 1'b1;
          end else if (rxd_re_w) begin
            rxfull_q <= 1'b0;
          end
          ready_q <= ~flow_w | ~rxfull_q;
        end
      end

      // Transmit frame, stop level doubles as filler in short frames
      assign tord_w = msb_w ? rev8(wdata_i[7:0]) : wdata_i[7:0];
      assign tpar_w = odd_w ? ~^wdata_i[7:0] : ^wdata_i[7:0];
      // Length fixed at launch, a control write mid-frame cannot stretch it
      assign tlast_w = tnine_q ? `CSP_LAST_LONG : `CSP_LAST_SHORT;

      always @(posedge clock_i) begin
        tdone_q <= 1'b0;
        if (reset_i) begin
          tst_q <= T_IDLE;
          tsh_q <= 11'h7ff;
          tsub_q <= 4'h0;
          tidx_q <= 4'h0;
          txd_q <= 1'b1;
          tnine_q <= 1'b0;
        end else begin
          case (tst_q)
            T_IDLE: begin
              txd_q <= spl_w;
              // Writes while busy are dropped; software polls the busy bit
              if (txd_we_w) begin
                // Parity and width are taken here, together with the data
                tsh_q <= {spl_w, nine_w ? tpar_w : spl_w, tord_w, stl_w};
                tnine_q <= nine_w;
                tst_q <= T_HOLD;
              end
            end
            T_HOLD: begin
              // Frames begin on a tick so the first bit is full length
              if (tick_w && (~flow_w || peer_ready_i[p])) begin
                tst_q <= T_SEND;
                txd_q <= tsh_q[0];
                tsub_q <= 4'h0;
                tidx_q <= 4'h0;
              end
            end
            T_SEND: begin
              if (tick_w) begin
                tsub_q <= tsub_q + 4'h1;
                if (tsub_q == `CSP_OVS_LAST) begin
                  if (tidx_q == tlast_w) begin
                    tst_q <= T_IDLE;
                    tdone_q <= 1'b1;
                  end else begin
                    tidx_q <= tidx_q + 4'h1;
                    tsh_q <= {1'b1, tsh_q[10:1]};
                    txd_q <= tsh_q[1];
                  end
                end
              end
            end
            default: tst_q <= T_IDLE;
          endcase
        end
      end

      // Read view of this port
      always @* begin
        prd_d = 32'h00000000;
        case (addr_i[4:0])
          `CSP_OFF_CTRL: prd_d[`CSP_CTRL_W-1:0] = ctrl_q;
          `CSP_OFF_STAT: begin
            prd_d[`CSP_EVT_W-1:0] = stat_q;
            prd_d[`CSP_S_TXBUSY] = txbusy_w;
            prd_d[`CSP_S_RXFULL] = rxfull_q;
          end
          `CSP_OFF_MASK: prd_d[`CSP_EVT_W-1:0] = mask_q;
          `CSP_OFF_RXD: prd_d[7:0] = rxbuf_q;
          default: prd_d = 32'h00000000;
        endcase
        if (!sel_w) prd_d = 32'h00000000;
      end

      assign rd_f[32*p+31:32*p] = prd_d;
      // Level request while any enabled event of this port is pending
      assign irq_f[p] = |(stat_q & mask_q);
      assign txd_o[p] = txd_q;
      assign own_ready_o[p] = ready_q;
    end
  endgenerate

  // Read data one cycle after the strobe, zero otherwise and for holes
  integer k;
  reg [31:0] rd_d;
  always @* begin
    rd_d = 32'h00000000;
    for (k = 0; k < PORTS; k = k + 1) rd_d = rd_d | rd_f[32*k +: 32];
  end

  always @(posedge clock_i) begin
    if (reset_i) begin
      rdata_o <= 32'h00000000;
      irq_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_d : 32'h00000000;
      irq_o <= |irq_f;
    end
  end
endmodule
`default_nettype wire

// *** test/csp_chk.sv ***
// Port assertions for the dual serial port
`timescale 1ns/10ps
`default_nettype none
`include "csp_regs.vh"
module csp_chk #(
  parameter CLK_HZ = 100000000,
  parameter PORTS = 2
) (
  // Clock, reset and register port
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  // Serial lines
  input wire logic [PORTS-1:0] rxd_i,
  input wire logic [PORTS-1:0] txd_o,
  input wire logic [PORTS-1:0] peer_ready_i,
  input wire logic [PORTS-1:0] own_ready_o
);
  // Shadow of port 0 flow and stop level, and whether any mask bit is set
  logic flow_q;
  logic stop_q;
  logic [1:0] msk_q;
  always @(posedge clock_i) begin
    if (reset_i) begin
      flow_q <= 1'b0;
      stop_q <= 1'b1;
      msk_q <= 2'b00;
    end else if (wr_i && addr_i[7:6] == 2'b00) begin
      if (addr_i[5:0] == 6'h00) begin
        flow_q <= wdata_i[`CSP_C_FLOW];
        stop_q <= wdata_i[`CSP_C_SPLVL];
      end
      if (addr_i[4:0] == `CSP_OFF_MASK) begin
        msk_q[addr_i[5]] <= |wdata_i[4:0];
      end
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  rd_idle_a: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data not zero");
  hole_zero_a: assert property (rd_i && addr_i[4:0] > `CSP_OFF_RXD |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  ctl_width_a: assert property (rd_i && addr_i[4:0] == 5'h00 |=> rdata_o[31:12] == 20'h0)
    else $error("control upper bits set");
  // Idle level moves after a control write, so those changes are exempt
  bit_hold0_a: assert property ($changed(txd_o[0]) && !$past(wr_i) && !$past(wr_i, 2) |=> $stable(txd_o[0]) [*8])
    else $error("port 0 bit too short");
  bit_hold1_a: assert property ($changed(txd_o[1]) && !$past(wr_i) && !$past(wr_i, 2) |=> $stable(txd_o[1]) [*8])
    else $error("port 1 bit too short");
  flow_hold_a: assert property (flow_q && !peer_ready_i[0] && txd_o[0] == stop_q |=> txd_o[0] == stop_q)
    else $error("frame sent to unready partner");
  ready_noflow_a: assert property (!flow_q [*3] |-> own_ready_o[0])
    else $error("ready low with flow off");
  irq_quiet_a: assert property (msk_q == 2'b00 [*2] |-> !irq_o)
    else $error("interrupt with all masked");
  cover property (rd_i && addr_i[4:0] == `CSP_OFF_RXD);
  cover property (irq_o);
  cover property (flow_q && !peer_ready_i[0]);
endmodule
bind csp_top csp_chk #(.CLK_HZ(CLK_HZ), .PORTS(PORTS)) chk_i (.clock_i(clock_i),
  .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .rxd_i(rxd_i), .txd_o(txd_o),
  .peer_ready_i(peer_ready_i), .own_ready_o(own_ready_o));
`default_nettype wire

// *** test/csp_peer.sv ***
// Behavioural serial partner that sends and captures frames
`timescale 1ns/10ps
`default_nettype none
module csp_peer #(
  parameter BITC = 160
) (
  // Clock
  input wire logic clk_i,
  // Serial lines
  input wire logic line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // cfg: parity on, odd, start level, stop level, msb first
  function automatic logic [9:0] frame(input logic [7:0] d, input logic [4:0] cfg);
    logic [9:0] r;
    int i;
    for (i = 0; i < 8; i++) r[i] = cfg[4] ? d[7 - i] : d[i];
    r[8] = cfg[0] ? (^d ^ cfg[1]) : cfg[3];
    r[9] = cfg[3];
    return r;
  endfunction
  task automatic put(input logic b, input int c);
    line_o <= b;
    repeat (c) @(posedge clk_i);
  endtask
  // Line rests at the stop level between frames
  task automatic idle(input logic lvl);
    @(posedge clk_i);
    line_o <= lvl;
    repeat (20) @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] d, input logic [4:0] cfg, input logic bp, input logic bs);
    logic [9:0] f;
    int i;
    int n;
    f = frame(d, cfg);
    n = cfg[0] ? 10 : 9;
    f[8] = f[8] ^ (bp & cfg[0]);
    f[n - 1] = f[n - 1] ^ bs;
    @(posedge clk_i);
    put(cfg[2], BITC);
    // A bad stop is cut short so the receiver cannot take it for a start
    for (i = 0; i < n; i++) put(f[i], (bs && i == n - 1) ? BITC * 9 / 16 : BITC);
    line_o <= cfg[3];
  endtask
  task automatic recv(input logic [4:0] cfg, output logic [9:0] got, output logic ok);
    int i;
    int n;
    got = 10'h0;
    for (n = 0; n < 4000 && line_i !== cfg[2]; n++) @(posedge clk_i);
    ok = (line_i === cfg[2]);
    repeat (BITC / 2) @(posedge clk_i);
    for (i = 0; i < 10; i++) begin
      repeat (BITC) @(posedge clk_i);
      got[i] = line_i;
    end
  endtask
endmodule
`default_nettype wire

// *** test/csp_top_bench.sv ***
// Self-checking bench for the dual serial port
`timescale 1ns/10ps
`default_nettype none
`include "csp_regs.vh"
module csp_top_bench;
  // Lower clock figure gives ten cycles a tick at 9600
  localparam int BITC = 160;
  localparam logic [7:0] CT = {3'h0, `CSP_OFF_CTRL};
  localparam logic [7:0] ST = {3'h0, `CSP_OFF_STAT};
  localparam logic [7:0] MK = {3'h0, `CSP_OFF_MASK};
  localparam logic [7:0] TX = {3'h0, `CSP_OFF_TXD};
  localparam logic [7:0] RX = {3'h0, `CSP_OFF_RXD};
  localparam logic [7:0] P1 = 8'h20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [1:0] rdy = 2'b11;
  wire [31:0] rdata;
  wire irq;
  wire [1:0] rxd;
  wire [1:0] txd;
  wire [1:0] own;
  int n_errors = 0;
  int check_count = 0;
  int i;
  int n;
  logic [31:0] v;
  logic [9:0] got;
  logic ok;
  logic [7:0] b;
  logic [7:0] d;
  logic [5:0] tab [4] = '{6'h08, 6'h09, 6'h17, 6'h07};
  initial forever #5 clk = ~clk;
  csp_top #(.CLK_HZ(1600000), .PORTS(2)) dut (.clock_i(clk), .reset_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .rxd_i(rxd),
    .txd_o(txd), .peer_ready_i(rdy), .own_ready_o(own));
  csp_peer #(.BITC(BITC)) p0 (.clk_i(clk), .line_i(txd[0]), .line_o(rxd[0]));
  csp_peer #(.BITC(BITC)) p1 (.clk_i(clk), .line_i(txd[1]), .line_o(rxd[1]));
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    addr <= a;
    wdata <= x;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 x = rdata;
  endtask
  task automatic ck(input logic [7:0] a, input logic [31:0] e, input string what);
    rd_reg(a, v);
    chk(what, e, v);
  endtask
  task automatic wait_bit(input logic [7:0] a, input int k);
    v = 32'h0;
    for (n = 0; n < 4000 && v[k] !== 1'b1; n++) rd_reg(a, v);
    chk("status wait", 32'h1, {31'h0, v[k]});
    if (v[k] !== 1'b1) report_and_stop();
  endtask
  // Idle levels follow the new stop level quickly, before a false start matures
  task automatic cfg_both(input logic [5:0] c);
    wr_reg(CT, {20'h0, 4'h3, 2'b00, c});
    wr_reg(P1 + CT, {20'h0, 4'h3, 2'b00, c});
    p0.idle(c[3]);
    p1.idle(c[3]);
  endtask
  task automatic tx_check(input logic [7:0] x, input logic [4:0] c);
    p0.recv(c, got, ok);
    chk("tx start", 32'h1, {31'h0, ok});
    if (ok !== 1'b1) report_and_stop();
    chk("tx frame", {22'h0, p0.frame(x, c)}, {22'h0, got});
    wait_bit(ST, `CSP_S_TXDONE);
    wr_reg(ST, 32'h1f);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (b = 8'h00; b < 8'h40; b += 8'h20) begin
      ck(b + CT, 32'h308, "ctrl reset");
      ck(b + ST, 32'h0, "stat reset");
      ck(b + MK, 32'h0, "mask reset");
    end
    ck(8'h14, 32'h0, "unmapped");
    for (i = 0; i < 4; i++) begin
      d = 8'h35 + 8'h4b * i[7:0];
      cfg_both(tab[i]);
      wr_reg(TX, {24'h0, d});
      tx_check(d, tab[i][4:0]);
      p1.send(d, tab[i][4:0], 1'b0, 1'b0);
      ck(P1 + ST, 32'h201, "rx status");
      ck(P1 + RX, {24'h0, d}, "rx data");
      wr_reg(P1 + ST, 32'h1f);
    end
    // Bad parity, then bad stop level
    for (i = 0; i < 2; i++) begin
      p1.send(8'h3c, 5'h07, i == 0, i == 1);
      ck(P1 + ST, i ? 32'h209 : 32'h205, "error status");
      rd_reg(P1 + RX, v);
      wr_reg(P1 + ST, 32'h1f);
    end
    p1.send(8'ha1, 5'h07, 1'b0, 1'b0);
    p1.send(8'hb2, 5'h07, 1'b0, 1'b0);
    ck(P1 + ST, 32'h211, "overrun");
    ck(P1 + RX, 32'hb2, "newest data");
    ck(P1 + ST, 32'h11, "overrun kept");
    wr_reg(P1 + ST, 32'h10);
    ck(P1 + ST, 32'h1, "one bit cleared");
    wr_reg(P1 + MK, 32'h1);
    tick();
    tick();
    chk("irq raised", 32'h1, {31'h0, irq});
    wr_reg(P1 + ST, 32'h1f);
    tick();
    tick();
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr_reg(P1 + MK, 32'h0);
    // Flow control: hold while partner not ready, own ready drops when full
    cfg_both(6'h28);
    wr_reg(ST, 32'h1f);
    rdy <= 2'b10;
    wr_reg(TX, 32'h5a);
    repeat (3 * BITC) @(posedge clk);
    ck(ST, 32'h100, "held busy");
    chk("line held", 32'h1, {31'h0, txd[0]});
    @(posedge clk);
    rdy <= 2'b11;
    tx_check(8'h5a, 5'h08);
    p1.send(8'h66, 5'h08, 1'b0, 1'b0);
    chk("ready low", 32'h0, {31'h0, own[1]});
    rd_reg(P1 + RX, v);
    tick();
    tick();
    chk("ready back", 32'h1, {31'h0, own[1]});
    for (i = 0; i < 12; i++) begin
      wr_reg(CT, {20'h0, i[3:0], 8'h08});
      ck(CT, {20'h0, i[3:0], 8'h08}, "rate field");
    end
    ck(P1 + CT, 32'h328, "other port");
    wr_reg(CT, 32'ha08);
    wr_reg(TX, 32'h01);
    for (n = 0; n < 200 && txd[0] !== 1'b0; n++) tick();
    for (n = 0; n < 200 && txd[0] === 1'b0; n++) tick();
    chk("bit length", 32'h10, n);
    wait_bit(ST, `CSP_S_TXDONE);
    report_and_stop();
  end
endmodule
`default_nettype wire
